// [common/tms_pkg.sv]
// constants, register map and types for the touch matrix scan sequencer
package tms_pkg;
    localparam int NUM_X = 8;
    localparam int NUM_Y = 3;
    localparam int NUM_KEYS = NUM_X * NUM_Y;
    localparam int KEY_W = 5;
    localparam int VAL_W = 12;
    localparam int CLK_PERIOD_PS = 8000;
    // charge-capture dwell per drive pulse, fixed
    localparam int DWELL_TIME_PS = 375000;
    localparam int DWELL_CYC = (DWELL_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // self-check duration after each scan
    localparam int SELFCHECK_TIME_US = 5000;
    localparam int SELFCHECK_CYC = SELFCHECK_TIME_US * 1000 / (CLK_PERIOD_PS / 1000);
    // default burst gap 0.5 ms
    localparam int BURST_GAP_TIME_US = 500;
    localparam logic [31:0] BURST_GAP_RST = 32'(BURST_GAP_TIME_US * 1000000 / CLK_PERIOD_PS);

    // register byte addresses
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_MASK = 12'h008;
    localparam logic [11:0] ADDR_SCAN = 12'h00C;
    localparam logic [11:0] ADDR_GAP = 12'h010;
    localparam logic [11:0] ADDR_FLOOR = 12'h014;
    localparam logic [11:0] ADDR_KCFG_BASE = 12'h040;
    localparam logic [11:0] ADDR_KRES_BASE = 12'h100;
    localparam logic [11:0] KEY_SPAN = 12'h060;

    // control bits
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_RECAL_BIT = 1;
    // status / mask bits
    localparam int EV_SCAN_DONE = 0;
    localparam int EV_CAL_DONE = 1;
    localparam int EV_FAULT = 2;
    localparam int EV_W = 3;

    // per-key config word: [3:0] detect limit, [15:8] burst pulse count
    localparam int KCFG_NORMAL_DETECT_INTEGRATOR_LIMIT_LSB = 0;
    localparam int NORMAL_DETECT_INTEGRATOR_LIMIT_W = 4;
    localparam int KCFG_BL_LSB = 8;
    localparam int BL_W = 8;
    localparam logic [31:0] KCFG_RST = 32'h0000_1001;

    // per-key result word
    localparam int KRES_SIG_LSB = 0;
    localparam int KRES_REF_LSB = 12;
    localparam int KRES_DET_BIT = 24;
    localparam int KRES_LOW_BIT = 25;
    localparam int KRES_CAL_BIT = 26;
    localparam int KRES_FAIL_BIT = 27;

    // scan state readback fields
    localparam int SCAN_KEY_LSB = 0;
    localparam int SCAN_CNT_LSB = 8;
    localparam int SCAN_ST_LSB = 16;
    localparam int SCAN_CAL_BIT = 20;

    localparam logic [VAL_W-1:0] FLOOR_RST = 12'h000;

    typedef enum logic [2:0] {
        TMS_IDLE, TMS_FIND, TMS_BURST, TMS_CONV, TMS_GAP, TMS_CHECK
    } tms_state_e;
endpackage

// [core/tms_burst_unit.sv]
// burst pulse generator: drive pulses with a fixed dwell capture window
`timescale 1ns/1ps
module tms_burst_unit
    import tms_pkg::*;
#(
    parameter int DWELL = DWELL_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic [BL_W-1:0] pulse_count,
    output logic drive,
    output logic capture,
    output logic done
);
    logic [15:0] dwell_ff;
    logic [BL_W-1:0] left_ff;
    logic phase_hi_ff;
    logic busy_ff;
    logic done_ff;
    wire dwell_end = (dwell_ff == 16'(DWELL - 1));
    wire last_pulse = (left_ff <= 8'h01);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dwell_ff <= 16'h0000;
            left_ff <= 8'h00;
            phase_hi_ff <= 1'b0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (start && !busy_ff) begin
                busy_ff <= 1'b1;
                phase_hi_ff <= 1'b1;
                dwell_ff <= 16'h0000;
                left_ff <= pulse_count;
            end else if (busy_ff) begin
                dwell_ff <= dwell_end ? 16'h0000 : dwell_ff + 16'h0001;
                // (R14) fixed dwell window
                if (dwell_end) begin
                    phase_hi_ff <= !phase_hi_ff;
                    if (!phase_hi_ff) begin
                        left_ff <= left_ff - 8'h01;
                    end
                    if (!phase_hi_ff && last_pulse) begin
                        busy_ff <= 1'b0;
                        done_ff <= 1'b1;
                    end
                end
            end
        end
    end

    assign drive = busy_ff && phase_hi_ff;
    // charge is captured for the whole drive-high half of each pulse, same as drive
    assign capture = busy_ff && phase_hi_ff;
    assign done = done_ff;
endmodule // tms_burst_unit

// [core/tms_scan_top.sv]
// touch matrix scan sequencer with burst paring, self-check and APB registers
//
// Notes on behaviour
// (R1) a key whose detect limit is zero counts as disabled
// (R2) keys scan X0..X7 within a Y line, then the next Y line
// (R3) one key's burst and conversion finish before the next key starts
// (R4) disabled keys take no burst timeslot
// (R5) scan cycle time scales with the enabled key count
// (R6) a disabled key never shows a detect flag
// (R7) a disabled key reports zero signal and zero reference
// (R8) a disabled key shows low-signal error only when the floor exceeds zero
// (R9) a disabled key shows calibrating only during the scan after reset or recal
// (R10) a disabled key always shows failed calibration
// (R11) a self-check of about five milliseconds follows every complete scan
// (R12) response time follows from slots times gap plus self-check, times limit
// (R13) all timing comes from pclk; there is no external clock input
// (R14) each drive pulse has a fixed 375 ns dwell window
// (R15) after the self-check the scan restarts at the lowest enabled key
`timescale 1ns/1ps
module tms_scan_top
    import tms_pkg::*;
#(
    parameter int SELFCHECK_CYCLES = SELFCHECK_CYC,
    parameter int KEYS = NUM_KEYS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [NUM_X-1:0] x_drive,
    output logic [NUM_Y-1:0] y_capture,
    input wire logic conv_valid,
    input wire logic [VAL_W-1:0] conv_value,
    input wire logic conv_touch,
    output logic irq
);
    // bus decode
    wire setup_ph = psel && !penable;
    wire access_ph = psel && penable;
    wire wr_en = access_ph && pwrite;
    wire rd_en = access_ph && !pwrite;
    wire in_kcfg = (paddr >= ADDR_KCFG_BASE) && (paddr < ADDR_KCFG_BASE + KEY_SPAN);
    wire in_kres = (paddr >= ADDR_KRES_BASE) && (paddr < ADDR_KRES_BASE + KEY_SPAN);
    wire [11:0] kcfg_off = paddr - ADDR_KCFG_BASE;
    wire [11:0] kres_off = paddr - ADDR_KRES_BASE;
    wire [KEY_W-1:0] kcfg_idx = kcfg_off[KEY_W+1:2];
    wire [KEY_W-1:0] kres_idx = kres_off[KEY_W+1:2];
    wire hit_ctrl = (paddr == ADDR_CTRL);
    wire hit_status = (paddr == ADDR_STATUS);
    wire hit_mask = (paddr == ADDR_MASK);
    wire hit_scan = (paddr == ADDR_SCAN);
    wire hit_gap = (paddr == ADDR_GAP);
    wire hit_floor = (paddr == ADDR_FLOOR);
    wire mapped = hit_ctrl || hit_status || hit_mask || hit_scan || hit_gap
        || hit_floor || in_kcfg || in_kres;
    wire aligned = (paddr[1:0] == 2'b00);

    // registers
    logic run_ff;
    logic [EV_W-1:0] status_ff;
    logic [EV_W-1:0] mask_ff;
    logic [31:0] gap_ff;
    logic [VAL_W-1:0] floor_ff;
    logic [31:0] kcfg_ff [KEYS];
    logic [VAL_W-1:0] sig_ff [KEYS];
    logic [VAL_W-1:0] ref_ff [KEYS];
    logic [NORMAL_DETECT_INTEGRATOR_LIMIT_W-1:0] integ_ff [KEYS];
    logic [KEYS-1:0] det_ff;
    logic [KEYS-1:0] calpend_ff;
    logic [KEYS-1:0] fail_ff;
    logic [31:0] prdata_ff;
    logic pslverr_ff;

    // sequencer state
    tms_state_e state_ff;
    tms_state_e nxt_state;
    logic [KEY_W-1:0] key_ff;
    logic [KEY_W-1:0] nxt_key;
    logic [31:0] slot_cnt_ff;
    logic [31:0] check_cnt_ff;
    logic cal_scan_ff;
    logic recal_req_ff;
    logic conv_seen_ff;

    // (R1) detect limit zero disables a key
    logic [KEYS-1:0] key_en;
    logic [KEY_W:0] en_count;
    always_comb begin
        en_count = '0;
        for (int k = 0; k < KEYS; k++) begin
            key_en[k] = (kcfg_ff[k][KCFG_NORMAL_DETECT_INTEGRATOR_LIMIT_LSB +: NORMAL_DETECT_INTEGRATOR_LIMIT_W] != '0);
            en_count = en_count + {{KEY_W{1'b0}}, key_en[k]};
        end
    end

    // (R4) search skips disabled keys
    logic [KEY_W-1:0] search_from;
    logic found;
    logic [KEY_W-1:0] found_key;
    always_comb begin
        found = 1'b0;
        found_key = '0;
        for (int k = KEYS - 1; k >= 0; k--) begin
            if (key_en[k] && (KEY_W'(k) >= search_from)) begin
                found = 1'b1;
                found_key = KEY_W'(k);
            end
        end
    end

    // (R13) burst engine, timed by pclk alone
    logic burst_start;
    logic burst_drive;
    logic burst_capture;
    logic burst_done;
    tms_burst_unit #(
        .DWELL(DWELL_CYC)
    ) u_burst (
        .pclk(pclk),
        .presetn(presetn),
        .start(burst_start),
        .pulse_count(kcfg_ff[key_ff][KCFG_BL_LSB +: BL_W]),
        .drive(burst_drive),
        .capture(burst_capture),
        .done(burst_done)
    );

    // (R2) key index maps to X first, then Y
    wire [2:0] cur_x = key_ff[2:0];
    wire [1:0] cur_y = key_ff[4:3];
    always_comb begin
        x_drive = '0;
        y_capture = '0;
        x_drive[cur_x] = burst_drive;
        if (cur_y < 2'(NUM_Y)) begin
            y_capture[cur_y] = burst_capture;
        end
    end

    wire slot_over = (slot_cnt_ff >= gap_ff - 32'h1);
    wire check_over = (check_cnt_ff >= 32'(SELFCHECK_CYCLES - 1));
    assign burst_start = (state_ff != TMS_BURST) && (nxt_state == TMS_BURST);
    assign search_from = (state_ff == TMS_GAP) ? key_ff + KEY_W'(1) : '0;

    always_comb begin
        nxt_state = state_ff;
        nxt_key = key_ff;
        case (state_ff)
            TMS_IDLE: begin
                if (run_ff) begin
                    nxt_state = TMS_FIND;
                end
            end
            // (R15) restart from lowest enabled key
            TMS_FIND: begin
                if (found) begin
                    nxt_key = found_key;
                    nxt_state = TMS_BURST;
                end else begin
                    nxt_state = TMS_CHECK;
                end
            end
            TMS_BURST: begin
                if (burst_done) nxt_state = TMS_CONV;
            end
            // (R3) wait for conversion before moving on
            TMS_CONV: begin
                if (conv_seen_ff) begin
                    nxt_state = TMS_GAP;
                end
            end
            // (R5) each enabled key holds one gap-long slot
            TMS_GAP: begin
                if (slot_over) begin
                    if (found) begin
                        nxt_key = found_key;
                        nxt_state = TMS_BURST;
                    end else begin
                        nxt_state = TMS_CHECK;
                    end
                end
            end
            // (R11) self-check after every scan
            TMS_CHECK: begin
                if (check_over) begin
                    nxt_state = run_ff ? TMS_FIND : TMS_IDLE;
                end
            end
            default: begin
                nxt_state = TMS_IDLE;
            end
        endcase
    end

    wire scan_end = (state_ff == TMS_CHECK) && check_over;
    wire key_conv = (state_ff == TMS_CONV) && conv_valid && !conv_seen_ff;
    wire bad_cal = key_conv && cal_scan_ff && (conv_value == '0);
    wire fault_ev = scan_end && |(key_en & fail_ff);
    wire [EV_W-1:0] events = {fault_ev, scan_end && cal_scan_ff, scan_end};
    wire status_rd = rd_en && hit_status;
    wire ctrl_wr = wr_en && hit_ctrl;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= TMS_IDLE;
            key_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            key_ff <= nxt_key;
        end
    end

    // (R12) slot and self-check counters set the response time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot_cnt_ff <= '0;
            check_cnt_ff <= '0;
            conv_seen_ff <= 1'b0;
        end else begin
            slot_cnt_ff <= burst_start ? 32'h0 : slot_cnt_ff + 32'h1;
            check_cnt_ff <= (state_ff == TMS_CHECK) ? check_cnt_ff + 32'h1 : 32'h0;
            conv_seen_ff <= (state_ff == TMS_BURST) ? 1'b0 : (conv_seen_ff || key_conv);
        end
    end

    // (R9) calibrating scan follows reset or recal command
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_scan_ff <= 1'b1;
            recal_req_ff <= 1'b0;
        end else begin
            if (scan_end) begin
                recal_req_ff <= 1'b0;
            end else if (ctrl_wr && pwdata[CTRL_RECAL_BIT]) begin
                recal_req_ff <= 1'b1;
            end
            if (scan_end) begin
                cal_scan_ff <= recal_req_ff || (ctrl_wr && pwdata[CTRL_RECAL_BIT]);
            end
        end
    end

    // per-key results
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int k = 0; k < KEYS; k++) begin
                sig_ff[k] <= '0;
                ref_ff[k] <= '0;
                integ_ff[k] <= '0;
            end
            det_ff <= '0;
            calpend_ff <= '1;
            fail_ff <= '0;
        end else begin
            if (scan_end && (recal_req_ff || (ctrl_wr && pwdata[CTRL_RECAL_BIT]))) begin
                calpend_ff <= '1;
            end
            if (key_conv) begin
                sig_ff[key_ff] <= conv_value;
                if (cal_scan_ff) begin
                    ref_ff[key_ff] <= conv_value;
                    calpend_ff[key_ff] <= 1'b0;
                    fail_ff[key_ff] <= bad_cal;
                end
                // consecutive touched samples confirm a detection
                if (!conv_touch || cal_scan_ff) begin
                    integ_ff[key_ff] <= '0;
                    det_ff[key_ff] <= 1'b0;
                end else if (integ_ff[key_ff] + 4'h1 >= kcfg_ff[key_ff][KCFG_NORMAL_DETECT_INTEGRATOR_LIMIT_LSB +: NORMAL_DETECT_INTEGRATOR_LIMIT_W]) begin
                    integ_ff[key_ff] <= kcfg_ff[key_ff][KCFG_NORMAL_DETECT_INTEGRATOR_LIMIT_LSB +: NORMAL_DETECT_INTEGRATOR_LIMIT_W];
                    det_ff[key_ff] <= 1'b1;
                end else begin
                    integ_ff[key_ff] <= integ_ff[key_ff] + 4'h1;
                end
            end
        end
    end

    // software registers; an event set wins over a read clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_ff <= 1'b0;
            status_ff <= '0;
            mask_ff <= '0;
            gap_ff <= BURST_GAP_RST;
            floor_ff <= FLOOR_RST;
            for (int k = 0; k < KEYS; k++) begin
                kcfg_ff[k] <= KCFG_RST;
            end
        end else begin
            status_ff <= (status_ff & ~(status_rd ? prdata_ff[EV_W-1:0] : '0)) | events;
            if (ctrl_wr) begin
                run_ff <= pwdata[CTRL_RUN_BIT];
            end
            if (wr_en && hit_mask) begin
                mask_ff <= pwdata[EV_W-1:0];
            end
            if (wr_en && hit_gap) begin
                gap_ff <= pwdata;
            end
            if (wr_en && hit_floor) begin
                floor_ff <= pwdata[VAL_W-1:0];
            end
            if (wr_en && in_kcfg && aligned) begin
                kcfg_ff[kcfg_idx] <= pwdata;
            end
        end
    end

    // result word; disabled keys show fixed patterns
    logic [31:0] kres_word;
    always_comb begin
        kres_word = '0;
        if (key_en[kres_idx]) begin
            kres_word[KRES_SIG_LSB +: VAL_W] = sig_ff[kres_idx];
            kres_word[KRES_REF_LSB +: VAL_W] = ref_ff[kres_idx];
            kres_word[KRES_DET_BIT] = det_ff[kres_idx];
            kres_word[KRES_LOW_BIT] = (sig_ff[kres_idx] < floor_ff);
            kres_word[KRES_CAL_BIT] = cal_scan_ff && calpend_ff[kres_idx];
            kres_word[KRES_FAIL_BIT] = fail_ff[kres_idx];
        end else begin
            // (R6) detect stays clear
            kres_word[KRES_DET_BIT] = 1'b0;
            // (R7) zero signal and reference are the defaults above
            // (R8) low-signal only with floor above zero
            kres_word[KRES_LOW_BIT] = (floor_ff != '0);
            // (R9) calibrating during cal scan only
            kres_word[KRES_CAL_BIT] = cal_scan_ff;
            // (R10) failed calibration always
            kres_word[KRES_FAIL_BIT] = 1'b1;
        end
    end

    wire [31:0] scan_word = {11'h000, cal_scan_ff, 1'b0, state_ff, 2'b00, en_count,
        3'b000, key_ff};
    wire [31:0] rd_mux = hit_ctrl ? {30'h0, recal_req_ff, run_ff}
        : hit_status ? {29'h0, status_ff}
        : hit_mask ? {29'h0, mask_ff}
        : hit_scan ? scan_word
        : hit_gap ? gap_ff
        : hit_floor ? {20'h0, floor_ff}
        : in_kcfg ? kcfg_ff[kcfg_idx]
        : in_kres ? kres_word
        : 32'h0000_0000;

    // read data captured in setup so the access phase needs no wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= '0;
            pslverr_ff <= 1'b0;
        end else if (setup_ph) begin
            prdata_ff <= rd_mux;
            pslverr_ff <= !(mapped && aligned);
        end
    end

    assign prdata = prdata_ff;
    assign pready = 1'b1;
    assign pslverr = access_ph && pslverr_ff;
    assign irq = |(status_ff & mask_ff);
endmodule // tms_scan_top

// [verif/tms_scan_asserts.sv]
// port-level assertions for the touch matrix scan sequencer
`timescale 1ns/1ps
module tms_scan_asserts
    import tms_pkg::*;
#(
    parameter int SELFCHECK_CYCLES = SELFCHECK_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [NUM_X-1:0] x_drive,
    input wire logic [NUM_Y-1:0] y_capture
);
    logic [31:0] hi_cnt_ff;
    logic [31:0] low_cnt_ff;
    logic [KEY_W-1:0] last_key_ff;
    logic [KEY_W-1:0] cur_key;
    wire drv_on = |x_drive;
    // low count saturates so a long idle never wraps to a short one
    wire [31:0] nxt_low = drv_on ? 32'h0 : (&low_cnt_ff ? low_cnt_ff : low_cnt_ff + 32'h1);
    wire [31:0] nxt_hi = drv_on ? hi_cnt_ff + 32'h1 : 32'h0;
    wire rise = drv_on && (low_cnt_ff != 32'h0);

    always_comb begin
        cur_key = '0;
        for (int i = 0; i < NUM_X; i++) begin
            if (x_drive[i]) cur_key = cur_key + KEY_W'(i);
        end
        for (int j = 0; j < NUM_Y; j++) begin
            if (y_capture[j]) cur_key = cur_key + KEY_W'(j * NUM_X);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_cnt_ff <= '0;
            low_cnt_ff <= '1;
            last_key_ff <= '1;
        end else begin
            hi_cnt_ff <= nxt_hi;
            low_cnt_ff <= nxt_low;
            if (rise) last_key_ff <= cur_key;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_start;
        $rose(drv_on);
    endsequence
    sequence s_end;
        $fell(drv_on);
    endsequence

    property p_ready;
        (psel && penable) |-> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("pready low in access phase");
    property p_x_onehot;
        $onehot0(x_drive);
    endproperty
    a_x_onehot: assert property (p_x_onehot) else $error("several drive lines high");
    property p_y_onehot;
        $onehot0(y_capture);
    endproperty
    a_y_onehot: assert property (p_y_onehot) else $error("several capture lines high");
    property p_pair;
        drv_on == (|y_capture);
    endproperty
    a_pair: assert property (p_pair) else $error("drive and capture out of step");
    property p_hold;
        drv_on ##1 drv_on |-> $stable(x_drive) && $stable(y_capture);
    endproperty
    a_hold: assert property (p_hold) else $error("key changed within a pulse");
    property p_dwell;
        s_end |-> hi_cnt_ff == DWELL_CYC;
    endproperty
    a_dwell: assert property (p_dwell) else $error("dwell window length wrong");
    property p_space;
        s_start |-> low_cnt_ff >= DWELL_CYC;
    endproperty
    a_space: assert property (p_space) else $error("pulse spacing too short");
    property p_order;
        s_start ##0 (cur_key > last_key_ff) |-> low_cnt_ff < SELFCHECK_CYCLES;
    endproperty
    a_order: assert property (p_order) else $error("self-check inside a scan");
    property p_check;
        s_start ##0 (cur_key < last_key_ff) |-> low_cnt_ff >= SELFCHECK_CYCLES;
    endproperty
    a_check: assert property (p_check) else $error("scan restart without self-check");
    property p_err;
        (psel && penable && paddr[1:0] != 2'b00) |-> pslverr;
    endproperty
    a_err: assert property (p_err) else $error("unaligned access not refused");
endmodule // tms_scan_asserts

bind tms_scan_top tms_scan_asserts #(.SELFCHECK_CYCLES(SELFCHECK_CYCLES)) u_tms_scan_asserts (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .x_drive(x_drive), .y_capture(y_capture));

// [verif/tms_afe_model.sv]
// behavioural sense front end: one conversion after each burst
`timescale 1ns/1ps
module tms_afe_model
    import tms_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [NUM_X-1:0] x_drive,
    output logic conv_valid,
    output logic [VAL_W-1:0] conv_value,
    output logic conv_touch
);
    logic was_on;
    int wait_cnt;
    always @(posedge pclk) begin
        was_on <= |x_drive;
        conv_valid <= 1'b0;
        // junk between results so a stale value is never trusted
        conv_value <= ~conv_value;
        conv_touch <= ~conv_touch;
        if (!presetn) begin
            wait_cnt <= -1;
            conv_value <= '0;
            conv_touch <= 1'b0;
        end else if (was_on && !(|x_drive)) begin
            // the burst's low half still follows the last fall
            wait_cnt <= DWELL_CYC + int'($urandom % 12);
        end else if (|x_drive) begin
            wait_cnt <= -1;
        end else if (wait_cnt > 0) begin
            wait_cnt <= wait_cnt - 1;
        end else if (wait_cnt == 0) begin
            conv_valid <= 1'b1;
            conv_value <= VAL_W'(1 + $urandom % 4000);
            conv_touch <= 1'b1;
            wait_cnt <= -1;
        end
    end
endmodule // tms_afe_model

// [verif/tms_scan_top_tb.sv]
// self-checking bench for the touch matrix scan sequencer
`timescale 1ns/1ps
module tms_scan_top_tb;
    import tms_pkg::*;
    localparam int SC = 2000;
    localparam int GAP = 300;
    typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} tms_exp_s;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic conv_valid, conv_touch;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [NUM_X-1:0] x_drive, x_prev;
    logic [NUM_Y-1:0] y_capture;
    logic [VAL_W-1:0] conv_value;
    logic [NUM_KEYS-1:0] en;
    tms_exp_s exp_q[$];
    int key_q[$];
    int error_cnt = 0;
    int compares = 0;
    int cyc = 0;

    tms_scan_top #(.SELFCHECK_CYCLES(SC), .KEYS(NUM_KEYS)) u_tms_scan_top (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .x_drive(x_drive), .y_capture(y_capture), .conv_valid(conv_valid),
        .conv_value(conv_value), .conv_touch(conv_touch), .irq(irq));
    tms_afe_model u_tms_afe_model (.pclk(pclk), .presetn(presetn), .x_drive(x_drive),
        .conv_valid(conv_valid), .conv_value(conv_value), .conv_touch(conv_touch));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
        compares++;
        if (got !== ex) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic test_done();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       input logic [31:0] ex, input logic [31:0] mk, input logic er);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        exp_q.push_back('{ex, mk, er});
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (n >= 40) begin
            cmp("pready", 32'h1, 32'h0);
            test_done();
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_irq(output int t);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 20000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 20000) begin
            cmp("irq wait", 32'h1, 32'h0);
            test_done();
        end
        t = cyc;
    endtask

    function automatic int key_of(input logic [NUM_X-1:0] x, input logic [NUM_Y-1:0] y);
        int k;
        k = 0;
        for (int i = 0; i < NUM_X; i++) if (x[i]) k += i;
        for (int j = 0; j < NUM_Y; j++) if (y[j]) k += j * NUM_X;
        return k;
    endfunction

    // watcher: takes the oldest note whenever an access phase completes, read or write, or a new burst shows
    always @(posedge pclk) begin
        tms_exp_s e;
        cyc <= cyc + 1;
        x_prev <= x_drive;
        if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            cmp("prdata", e.d & e.m, prdata & e.m);
            cmp("pslverr", {31'h0, e.e}, {31'h0, pslverr});
        end
        if (x_drive != '0 && x_prev == '0 && key_q.size() > 0) begin
            cmp("burst key", key_q.pop_front(), key_of(x_drive, y_capture));
        end
    end

    initial begin
        int t1, t2, n, enabled_key_count;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        void'($urandom(53353));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ADDR_GAP, 32'h0, BURST_GAP_RST, '1, 1'b0);
        apb(1'b0, ADDR_FLOOR, 32'h0, 32'h0, '1, 1'b0);
        apb(1'b0, ADDR_KCFG_BASE + 12'h014, 32'h0, KCFG_RST, '1, 1'b0);
        apb(1'b0, 12'h018, 32'h0, 32'h0, '1, 1'b1);
        apb(1'b1, 12'h011, 32'h5, 32'h0, 32'h0, 1'b1);
        apb(1'b0, ADDR_GAP, 32'h0, BURST_GAP_RST, '1, 1'b0);
        apb(1'b1, ADDR_GAP, 32'(GAP), 32'h0, 32'h0, 1'b0);
        // key 0 off to see the restart skip it, top key always on
        en = NUM_KEYS'($urandom);
        en[0] = 1'b0;
        en[NUM_KEYS-1] = 1'b1;
        enabled_key_count = 0;
        for (int k = 0; k < NUM_KEYS; k++) begin
            apb(1'b1, ADDR_KCFG_BASE + 12'(4 * k), 32'h100 | 32'(en[k]), 0, 0, 0);
            enabled_key_count += int'(en[k]);
        end
        repeat (3) for (int k = 0; k < NUM_KEYS; k++) if (en[k]) key_q.push_back(k);
        apb(1'b1, ADDR_CTRL, 32'h1, 32'h0, 32'h0, 1'b0);
        apb(1'b0, ADDR_KRES_BASE, 32'h0, 32'h0C00_0000, 32'h0FFF_FFFF, 1'b0);
        rd = '0;
        n = 0;
        while (rd[EV_SCAN_DONE] !== 1'b1 && n < 1000) begin
            cmp("irq masked", 32'h0, {31'h0, irq});
            apb(1'b0, ADDR_STATUS, 32'h0, 32'h0, 32'h0, 1'b0);
            repeat (10) @(posedge pclk);
            n++;
        end
        cmp("scan done", 32'h1, {31'h0, rd[EV_SCAN_DONE]});
        apb(1'b1, ADDR_FLOOR, 32'(1 + $urandom % 4095), 32'h0, 32'h0, 1'b0);
        apb(1'b1, ADDR_MASK, 32'h1, 32'h0, 32'h0, 1'b0);
        wait_irq(t1);
        apb(1'b0, ADDR_STATUS, 32'h0, 32'h1, 32'h1, 1'b0);
        @(posedge pclk);
        cmp("irq cleared", 32'h0, {31'h0, irq});
        apb(1'b0, ADDR_KRES_BASE, 32'h0, 32'h0A00_0000, 32'h0FFF_FFFF, 1'b0);
        wait_irq(t2);
        apb(1'b0, ADDR_STATUS, 32'h0, 32'h1, 32'h1, 1'b0);
        cmp("scan period", 32'h1, 32'(t2 - t1 >= enabled_key_count * GAP + SC
            && t2 - t1 <= enabled_key_count * (GAP + 4) + SC + 20));
        apb(1'b1, ADDR_CTRL, 32'h0, 32'h0, 32'h0, 1'b0);
        cmp("bursts left", 32'h0, 32'(key_q.size()));
        test_done();
    end
endmodule // tms_scan_top_tb
